// >>> hdl/mcu_instruction_timing.sv
// instruction sequencing and execution core of a small 8-bit controller
`timescale 1ns/10ps
`default_nettype none
module mcu_instruction_timing
  import mcu_core_pkg::*;
#(
  parameter int STACK_DEPTH = STACK_DEPTH_DEF
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // program memory
  output logic      [PC_W-1:0]   prog_addr_out,
  input  wire logic [INST_W-1:0] prog_data_in,
  // data memory
  output logic      [DATA_W-1:0] dmem_addr_out,
  output logic      [DATA_W-1:0] dmem_wdata_out,
  output logic                   dmem_we_out,
  input  wire logic [DATA_W-1:0] dmem_rdata_in,
  // core state
  output logic      [DATA_W-1:0] acc_out,
  output logic                   carry_out,
  output logic                   zero_out,
  output logic                   global_interrupt_enable_out,
  output logic                   cycle_start_out
);

  localparam int               SP_W   = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;
  localparam logic [SP_W-1:0]  SP_ONE = SP_W'(1);

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // returns {carry, result}
  function automatic logic [8:0] rotate(input logic [7:0] v, input logic c,
                                        input logic left, input logic thru);
    logic [8:0] r;
    r = 9'h000;
    if (left) begin
      r = thru ? {v[7], v[6:0], c} : {c, v[6:0], v[7]};
    end else begin
      r = thru ? {v[0], c, v[7:1]} : {c, v[0], v[7:1]};
    end
    rotate = r;
  endfunction

  cycle_state_type  state;
  cycle_state_type  next_state;
  logic [1:0]       phase;
  logic [1:0]       next_phase;
  logic [PC_W-1:0]  pc;
  logic [PC_W-1:0]  next_pc;
  logic [PC_W-1:0]  prog_addr;
  logic [PC_W-1:0]  next_prog_addr;
  logic [INST_W-1:0] inst;
  logic [INST_W-1:0] next_inst;
  logic [7:0]       dmem_addr;
  logic [7:0]       next_dmem_addr;
  logic [7:0]       wdata;
  logic [7:0]       next_wdata;
  logic             we;
  logic             next_we;
  logic [7:0]       operand;
  logic [7:0]       next_operand;
  logic [7:0]       acc;
  logic [7:0]       next_acc;
  logic             carry;
  logic             next_carry;
  logic             zero;
  logic             next_zero;
  logic             gie;
  logic             next_gie;
  logic [SP_W-1:0]  sp;
  logic [SP_W-1:0]  next_sp;
  logic             cstart;
  logic             next_cstart;

  op_type           op;
  logic             exec_last;
  logic [PC_W-1:0]  seq_pc;
  logic [PC_W-1:0]  stack_rd;
  logic [8:0]       sum9;
  logic [8:0]       diff9;
  logic [8:0]       rot9;
  logic [7:0]       src;
  logic [7:0]       res;
  logic             wr_acc;
  logic             wr_mem;
  logic             set_z;
  logic             two;
  logic             unary;

  assign op        = op_type'(inst[OP_MSB:OP_LSB]);
  assign exec_last = (phase == PHASE_LAST) && (state == ST_EXEC);
  assign seq_pc    = pc + 11'h001;
  assign src       = (op == OP_ADD_A_X || op == OP_SUB_A_X) ? inst[7:0] : operand;
  assign sum9      = {1'b0, acc} + {1'b0, src};
  assign diff9     = {1'b0, acc} - {1'b0, src};
  assign rot9      = rotate(operand, carry, op == OP_ROTATE_LEFT || op == OP_ROTATE_LEFT_C,
                            op == OP_ROTATE_RIGHT_C || op == OP_ROTATE_LEFT_C);

  // the return address of a call is written at the same edge that moves the pointer
  return_stack #(
    .DEPTH       (STACK_DEPTH),
    .WIDTH       (PC_W),
    .AW          (SP_W)
  ) u_stack (
    .clk_in      (clk_in),
    .wr_en_in    (exec_last && op == OP_CALL),
    .wr_addr_in  (sp),
    .wr_data_in  (seq_pc),
    .rd_addr_in  (sp - SP_ONE),
    .rd_data_out (stack_rd)
  );

  always_comb begin
    next_phase     = phase + 2'h1;
    next_cstart    = (next_phase == PHASE_FIRST);
    next_state     = state;
    next_pc        = pc;
    next_prog_addr = prog_addr;
    next_inst      = inst;
    next_dmem_addr = dmem_addr;
    next_wdata     = wdata;
    next_we        = 1'b0;
    next_operand   = operand;
    next_acc       = acc;
    next_carry     = carry;
    next_zero      = zero;
    next_gie       = gie;
    next_sp        = sp;
    res            = 8'h00;
    wr_acc         = 1'b0;
    wr_mem         = 1'b0;
    set_z          = 1'b0;
    two            = 1'b0;
    unary          = 1'b0;
    if (phase == PHASE_FETCH && state != ST_TABLE) begin
      next_inst      = prog_data_in;
      next_dmem_addr = prog_data_in[7:0];
    end
    if (phase == PHASE_FETCH && state == ST_TABLE) begin
      next_wdata = prog_data_in[7:0];
    end
    if (phase == PHASE_READ) begin
      next_operand = dmem_rdata_in;
    end
    if (phase == PHASE_LAST) begin
      case (state)
        ST_EXEC: begin
          next_pc = seq_pc;
          case (op)
            OP_MOV_A_M: begin
              res    = operand;
              wr_acc = 1'b1;
            end
            OP_MOV_M_A: begin
              res    = acc;
              wr_mem = 1'b1;
            end
            OP_MOV_A_X: begin
              res    = inst[7:0];
              wr_acc = 1'b1;
            end
            OP_ADD_A_M, OP_ADD_A_X: begin
              res        = sum9[7:0];
              next_carry = sum9[8];
              wr_acc     = 1'b1;
              set_z      = 1'b1;
            end
            OP_SUB_A_M, OP_SUB_A_X: begin
              res        = diff9[7:0];
              next_carry = ~diff9[8];
              wr_acc     = 1'b1;
              set_z      = 1'b1;
            end
            OP_AND_A_M, OP_OR_A_M, OP_XOR_A_M: begin
              res    = (op == OP_AND_A_M) ? (acc & operand) :
                       (op == OP_OR_A_M) ? (acc | operand) : (acc ^ operand);
              wr_acc = 1'b1;
              set_z  = 1'b1;
            end
            OP_COMPLEMENT: begin
              res   = ~operand;
              unary = 1'b1;
              set_z = 1'b1;
            end
            OP_INCREMENT, OP_DECREMENT: begin
              res   = (op == OP_INCREMENT) ? operand + 8'h01 : operand - 8'h01;
              unary = 1'b1;
              set_z = 1'b1;
            end
            OP_ROTATE_RIGHT, OP_ROTATE_LEFT: begin
              res   = rot9[7:0];
              unary = 1'b1;
            end
            OP_ROTATE_RIGHT_C, OP_ROTATE_LEFT_C: begin
              res        = rot9[7:0];
              next_carry = rot9[8];
              unary      = 1'b1;
            end
            OP_SET_BIT: begin
              res    = operand | bit_mask(inst[BIT_MSB:BIT_LSB]);
              wr_mem = 1'b1;
            end
            OP_CLR_BIT: begin
              res    = operand & ~bit_mask(inst[BIT_MSB:BIT_LSB]);
              wr_mem = 1'b1;
            end
            OP_SKIP_ZERO: begin
              two = (operand == 8'h00);
            end
            OP_SKIP_BIT_ZERO: begin
              two = ~operand[inst[BIT_MSB:BIT_LSB]];
            end
            OP_SKIP_BIT_SET: begin
              two = operand[inst[BIT_MSB:BIT_LSB]];
            end
            OP_JUMP: begin
              next_pc = inst[PC_W-1:0];
              two     = 1'b1;
            end
            OP_CALL: begin
              next_pc = inst[PC_W-1:0];
              next_sp = sp + SP_ONE;
              two     = 1'b1;
            end
            OP_RETURN, OP_RETURN_INT: begin
              next_pc = stack_rd;
              next_sp = sp - SP_ONE;
              two     = 1'b1;
              if (op == OP_RETURN_INT) begin
                next_gie = 1'b1;
              end
            end
            default: begin
            end
          endcase
          // taken skip moves pc on by two; the wait cycle fetches from pc + 2, so the skipped word is never fetched
          if (two && (op == OP_SKIP_ZERO || op == OP_SKIP_BIT_ZERO || op == OP_SKIP_BIT_SET)) begin
            next_pc = pc + 11'h002;
          end
          if (unary) begin
            wr_acc = inst[TO_ACC_BIT];
            wr_mem = ~inst[TO_ACC_BIT];
          end
          if (set_z) begin
            next_zero = (res == 8'h00);
          end
          if (wr_acc) begin
            next_acc = res;
          end
          if (wr_mem) begin
            next_wdata = res;
            next_we    = 1'b1;
            if (dmem_addr == PCL_ADDR) begin
              next_pc = {pc[PC_W-1:8], res};
              two     = 1'b1;
            end
          end
          if (op == OP_TABLE_READ) begin
            next_prog_addr = {TABLE_PAGE, acc};
            next_state     = ST_TABLE;
          end else begin
            next_prog_addr = next_pc;
            next_state     = two ? ST_WAIT : ST_EXEC;
          end
        end
        ST_TABLE: begin
          next_we        = 1'b1;
          next_prog_addr = pc;
          next_state     = ST_EXEC;
        end
        default: begin
          next_state = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase     <= PHASE_FIRST;
      cstart    <= 1'b1;
      state     <= ST_EXEC;
      pc        <= RESET_VECTOR;
      prog_addr <= RESET_VECTOR;
      inst      <= RESET_INST;
      dmem_addr <= 8'h00;
      wdata     <= 8'h00;
      we        <= 1'b0;
      operand   <= 8'h00;
      acc       <= 8'h00;
      carry     <= 1'b0;
      zero      <= 1'b0;
      gie       <= 1'b0;
      sp        <= '0;
    end else begin
      phase     <= next_phase;
      cstart    <= next_cstart;
      state     <= next_state;
      pc        <= next_pc;
      prog_addr <= next_prog_addr;
      inst      <= next_inst;
      dmem_addr <= next_dmem_addr;
      wdata     <= next_wdata;
      we        <= next_we;
      operand   <= next_operand;
      acc       <= next_acc;
      carry     <= next_carry;
      zero      <= next_zero;
      gie       <= next_gie;
      sp        <= next_sp;
    end
  end

  assign prog_addr_out               = prog_addr;
  assign dmem_addr_out               = dmem_addr;
  assign dmem_wdata_out              = wdata;
  assign dmem_we_out                 = we;
  assign acc_out                     = acc;
  assign carry_out                   = carry;
  assign zero_out                    = zero;
  assign global_interrupt_enable_out = gie;
  assign cycle_start_out             = cstart;

  a_phase_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (phase == PHASE_LAST) |=> (phase == PHASE_FIRST) ##1 (phase == PHASE_FETCH)
      ##1 (phase == PHASE_READ) ##1 (phase == PHASE_LAST))
    else $error("phase does not count four clocks");

  a_plain_one: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_MOV_A_M) |=> (state == ST_EXEC) [*4])
    else $error("move took more than one cycle");

  a_jump_two: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_JUMP) |=> (pc == $past(inst[PC_W-1:0])) ##0 (state == ST_WAIT) [*4]
      ##1 (state == ST_EXEC))
    else $error("jump did not take two cycles");

  a_pcl_write: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_MOV_M_A && dmem_addr == PCL_ADDR)
      |=> (state == ST_WAIT && pc[7:0] == $past(acc) && prog_addr == pc))
    else $error("low counter write did not jump");

  a_skip_taken: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_SKIP_ZERO && operand == 8'h00)
      |=> (state == ST_WAIT && pc == $past(pc) + 11'h002))
    else $error("taken skip wrong");

  a_skip_not: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_SKIP_BIT_SET && !operand[inst[BIT_MSB:BIT_LSB]])
      |=> (state == ST_EXEC && pc == $past(pc) + 11'h001))
    else $error("untaken skip wrong");

  a_add_carry: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_ADD_A_X)
      |=> (carry == (({1'b0, $past(acc)} + {1'b0, $past(inst[7:0])}) > 9'h0FF)))
    else $error("add carry wrong");

  a_logic_zero: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_XOR_A_M) |=> (zero == (acc == 8'h00)))
    else $error("zero flag wrong after logic");

  a_bit_rmw: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_SET_BIT) |=> (dmem_we_out
      && dmem_wdata_out == ($past(operand) | bit_mask($past(inst[BIT_MSB:BIT_LSB])))))
    else $error("bit set changed other bits");

  a_call_push: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_CALL) |=> (sp == $past(sp) + SP_ONE) ##4 (stack_rd == $past(pc, 5) + 11'h001))
    else $error("call did not save return address");

  a_ret_enable: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_RETURN) |=> $stable(gie))
    else $error("plain return changed global enable");

  a_return_from_interrupt_enable: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (exec_last && op == OP_RETURN_INT) |=> gie)
    else $error("interrupt return left enable clear");

  a_reset_start: assert property (
    @(posedge clk_in)
    rst_in |=> (phase == PHASE_FIRST && prog_addr == RESET_VECTOR && state == ST_EXEC))
    else $error("reset did not restart core");

endmodule
`default_nettype wire

// >>> hdl/return_stack.sv
// small return address memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module return_stack #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 11,
  parameter int AW    = 2
) (
  // clock
  input  wire logic             clk_in,
  // write side
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  // read side
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; read data is only used after a push
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule
`default_nettype wire

// >>> shared/mcu_core_pkg.sv
// constants, opcodes and states of the instruction timing core
package mcu_core_pkg;

  localparam int PC_W   = 11;
  localparam int DATA_W = 8;
  localparam int INST_W = 16;

  // instruction cycle phases, four system clocks each cycle
  localparam int           PHASES_PER_CYCLE = 4;
  localparam logic [1:0]   PHASE_FIRST      = 2'h0;
  localparam logic [1:0]   PHASE_FETCH      = 2'h1;
  localparam logic [1:0]   PHASE_READ       = 2'h2;
  localparam logic [1:0]   PHASE_LAST       = 2'h3;

  // reset values and fixed addresses
  localparam logic [10:0]  RESET_VECTOR     = 11'h000;
  localparam logic [15:0]  RESET_INST       = 16'h0000;
  localparam logic [7:0]   PCL_ADDR         = 8'h07;
  localparam logic [2:0]   TABLE_PAGE       = 3'h7;
  localparam int           STACK_DEPTH_DEF  = 4;

  // instruction word fields
  localparam int           OP_MSB           = 15;
  localparam int           OP_LSB           = 11;
  localparam int           TO_ACC_BIT       = 10;
  localparam int           BIT_MSB          = 10;
  localparam int           BIT_LSB          = 8;

  typedef enum logic [4:0] {
    OP_NOP           = 5'h00,
    OP_MOV_A_M       = 5'h01,
    OP_MOV_M_A       = 5'h02,
    OP_MOV_A_X       = 5'h03,
    OP_ADD_A_M       = 5'h04,
    OP_ADD_A_X       = 5'h05,
    OP_SUB_A_M       = 5'h06,
    OP_SUB_A_X       = 5'h07,
    OP_AND_A_M       = 5'h08,
    OP_OR_A_M        = 5'h09,
    OP_XOR_A_M       = 5'h0A,
    OP_COMPLEMENT    = 5'h0B,
    OP_INCREMENT     = 5'h0C,
    OP_DECREMENT     = 5'h0D,
    OP_ROTATE_RIGHT  = 5'h0E,
    OP_ROTATE_RIGHT_C = 5'h0F,
    OP_ROTATE_LEFT   = 5'h10,
    OP_ROTATE_LEFT_C = 5'h11,
    OP_SET_BIT       = 5'h12,
    OP_CLR_BIT       = 5'h13,
    OP_SKIP_ZERO     = 5'h14,
    OP_SKIP_BIT_ZERO = 5'h15,
    OP_SKIP_BIT_SET  = 5'h16,
    OP_JUMP          = 5'h17,
    OP_CALL          = 5'h18,
    OP_RETURN        = 5'h19,
    OP_RETURN_INT    = 5'h1A,
    OP_TABLE_READ    = 5'h1B
  } op_type;

  typedef enum logic [2:0] {
    ST_EXEC  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_TABLE = 3'b100
  } cycle_state_type;

endpackage

// >>> tb/mem_model.sv
// program and data memory model facing the core
`timescale 1ns/10ps
`default_nettype none
module mem_model
  import mcu_core_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // program memory
  input  wire logic [PC_W-1:0]   prog_addr_in,
  output logic      [INST_W-1:0] prog_data_out,
  // data memory
  input  wire logic [DATA_W-1:0] dmem_addr_in,
  input  wire logic [DATA_W-1:0] dmem_wdata_in,
  input  wire logic              dmem_we_in,
  output logic      [DATA_W-1:0] dmem_rdata_out
);
  logic [INST_W-1:0] prog [2**PC_W];
  logic [DATA_W-1:0] data [2**DATA_W];
  // table words sit in program memory and are read like any other word
  assign prog_data_out  = prog[prog_addr_in];
  assign dmem_rdata_out = data[dmem_addr_in];
  // write lands at the end of the strobe clock, as the core expects
  always @(posedge clk_in) begin
    if (dmem_we_in) begin
      data[dmem_addr_in] <= dmem_wdata_in;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the instruction timing core
`timescale 1ns/10ps
`default_nettype none
module testbench
  import mcu_core_pkg::*;
;
  localparam int TIMEOUT = 5000;
  logic              clk_in;
  logic              rst_in;
  logic [PC_W-1:0]   prog_addr;
  logic [INST_W-1:0] prog_data;
  logic [DATA_W-1:0] dmem_addr;
  logic [DATA_W-1:0] dmem_wdata;
  logic              dmem_we;
  logic [DATA_W-1:0] dmem_rdata;
  logic [DATA_W-1:0] acc;
  logic              carry;
  logic              zero;
  logic              gie;
  logic              cyc_start;
  int                errors;
  int                tests_run;
  int                cycles;

  mcu_instruction_timing mcu_instruction_timing_i (
    .clk_in(clk_in), .rst_in(rst_in), .prog_addr_out(prog_addr), .prog_data_in(prog_data),
    .dmem_addr_out(dmem_addr), .dmem_wdata_out(dmem_wdata), .dmem_we_out(dmem_we),
    .dmem_rdata_in(dmem_rdata), .acc_out(acc), .carry_out(carry), .zero_out(zero),
    .global_interrupt_enable_out(gie), .cycle_start_out(cyc_start));

  mem_model mem_model_i (
    .clk_in(clk_in), .prog_addr_in(prog_addr), .prog_data_out(prog_data),
    .dmem_addr_in(dmem_addr), .dmem_wdata_in(dmem_wdata), .dmem_we_in(dmem_we),
    .dmem_rdata_out(dmem_rdata));

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch rather than stalling the run
  initial begin
    cycles = 0;
    forever begin
      @(posedge clk_in);
      cycles++;
      if (cycles >= TIMEOUT) begin
        errors++;
        tally_and_finish();
      end
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic pw(input int a, input op_type op, input logic [10:0] arg);
    mem_model_i.prog[a] = {op, arg};
  endtask

  task automatic wipe();
    for (int i = 0; i < 2**PC_W; i++) begin
      mem_model_i.prog[i] = RESET_INST;
    end
    for (int i = 0; i < 2**DATA_W; i++) begin
      mem_model_i.data[i] = 8'h00;
    end
  endtask

  task automatic restart();
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("reset pc", prog_addr, RESET_VECTOR);
    check("reset phase", cyc_start, 1'b1);
    @(posedge clk_in);
    rst_in <= 1'b0;
  endtask

  // counts clocks until the fetch address reaches stop; four clocks per cycle
  task automatic run(input logic [PC_W-1:0] stop, input int cyc);
    int n;
    n = 0;
    while (prog_addr !== stop && n < 64) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("clocks to address", n, 4 * cyc);
  endtask

  task automatic s_move_arith();
    wipe();
    pw(0, OP_MOV_A_X, 11'h0F0);
    pw(1, OP_ADD_A_X, 11'h020);
    pw(2, OP_MOV_M_A, 11'h061);
    pw(3, OP_SUB_A_X, 11'h011);
    pw(4, OP_MOV_A_M, 11'h061);
    restart();
    run(2, 2);
    check("add sum", acc, 8'h10);
    check("add carry", carry, 1'b1);
    run(4, 2);
    check("sub result", acc, 8'hFF);
    check("sub borrow", carry, 1'b0);
    run(5, 1);
    check("load back", acc, 8'h10);
    check("stored byte", mem_model_i.data[8'h61], 8'h10);
  endtask

  task automatic s_logic();
    wipe();
    mem_model_i.data[8'h20] = 8'h0F;
    mem_model_i.data[8'h21] = 8'hFF;
    pw(0, OP_MOV_A_X, 11'h0F0);
    pw(1, OP_AND_A_M, 11'h020);
    pw(2, OP_XOR_A_M, 11'h020);
    pw(3, OP_COMPLEMENT, 11'h421);
    pw(4, OP_OR_A_M, 11'h020);
    restart();
    run(2, 2);
    check("and zero", {acc, 7'h00, zero}, 16'h0001);
    run(3, 1);
    check("xor nonzero", {acc, 7'h00, zero}, 16'h0F00);
    run(4, 1);
    check("cpl zero", {acc, 7'h00, zero}, 16'h0001);
    run(5, 1);
    check("or nonzero", {acc, 7'h00, zero}, 16'h0F00);
  endtask

  task automatic s_inc_rot();
    wipe();
    mem_model_i.data[8'h30] = 8'hFF;
    mem_model_i.data[8'h32] = 8'h01;
    pw(0, OP_INCREMENT, 11'h430);
    pw(1, OP_DECREMENT, 11'h031);
    pw(2, OP_ROTATE_RIGHT_C, 11'h432);
    pw(3, OP_ROTATE_LEFT_C, 11'h432);
    pw(4, OP_ROTATE_RIGHT, 11'h032);
    restart();
    run(1, 1);
    check("inc to acc", {acc, 7'h00, zero}, 16'h0001);
    run(2, 1);
    check("dec zero", zero, 1'b0);
    run(3, 1);
    check("rrc", {acc, 7'h00, carry}, 16'h0001);
    run(4, 1);
    check("rlc", {acc, 7'h00, carry}, 16'h0300);
    run(6, 2);
    check("rr keeps carry", carry, 1'b0);
    check("rr byte", mem_model_i.data[8'h32], 8'h80);
    check("inc src kept", mem_model_i.data[8'h30], 8'hFF);
    check("dec to mem", mem_model_i.data[8'h31], 8'hFF);
  endtask

  task automatic s_bits_skip();
    wipe();
    mem_model_i.data[8'h40] = 8'hA5;
    pw(0, OP_SET_BIT, 11'h140);
    pw(1, OP_CLR_BIT, 11'h740);
    pw(2, OP_SKIP_BIT_ZERO, 11'h340);
    pw(3, OP_MOV_A_X, 11'h055);
    pw(4, OP_SKIP_BIT_SET, 11'h340);
    pw(5, OP_MOV_A_X, 11'h066);
    pw(6, OP_SKIP_ZERO, 11'h041);
    pw(7, OP_MOV_A_X, 11'h077);
    restart();
    run(2, 2);
    run(4, 1);
    run(5, 2);
    run(6, 1);
    run(8, 1);
    run(9, 2);
    check("skipped moves", acc, 8'h66);
    check("bit rmw", mem_model_i.data[8'h40], 8'h27);
  endtask

  task automatic s_call_ret();
    wipe();
    pw(0, OP_CALL, 11'h100);
    pw(1, OP_MOV_A_X, 11'h011);
    pw(2, OP_CALL, 11'h300);
    pw(3, OP_JUMP, 11'h200);
    pw(11'h100, OP_MOV_A_X, 11'h022);
    pw(11'h101, OP_RETURN, 11'h000);
    pw(11'h300, OP_RETURN_INT, 11'h000);
    restart();
    run(11'h100, 1);
    run(11'h101, 2);
    check("sub body", acc, 8'h22);
    run(1, 1);
    run(2, 2);
    check("after return", {acc, 7'h00, gie}, 16'h1100);
    run(11'h300, 1);
    run(3, 2);
    check("enable set", gie, 1'b1);
    run(11'h200, 2);
    run(11'h201, 2);
    check("enable kept", gie, 1'b1);
  endtask

  task automatic s_pcl_table();
    wipe();
    pw(0, OP_MOV_A_X, 11'h010);
    pw(1, OP_MOV_M_A, {3'h0, PCL_ADDR});
    pw(11'h010, OP_TABLE_READ, 11'h050);
    mem_model_i.prog[{TABLE_PAGE, 8'h10}] = 16'hABCD;
    restart();
    run(1, 1);
    run(11'h010, 1);
    run({TABLE_PAGE, 8'h10}, 2);
    run(11'h011, 1);
    run(11'h012, 1);
    check("table byte", mem_model_i.data[8'h50], 8'hCD);
    check("pcl byte", mem_model_i.data[PCL_ADDR], 8'h10);
  endtask

  initial begin
    errors = 0;
    tests_run = 0;
    rst_in = 1'b1;
    s_move_arith();
    s_logic();
    s_inc_rot();
    s_bits_skip();
    s_call_ret();
    s_pcl_table();
    tally_and_finish();
  end
endmodule
`default_nettype wire
